// File: rtl/rpw_top.sv
`timescale 1ns/100ps
`include "rpw_map.svh"
module rpw_top
    import rpw_pkg::*;
#(
    parameter int NUM_IN  = 12,
    parameter int NUM_OUT = 10
)(
    input  wire logic               clk_i,
    input  wire logic               reset_i,
    input  wire logic               ce_i,
    input  wire logic               psel_i,
    input  wire logic               penable_i,
    input  wire logic               pwrite_i,
    input  wire logic [11:0]        paddr_i,
    input  wire logic [31:0]        pwdata_i,
    output logic      [31:0]        prdata_o,
    output logic                    pready_o,
    output logic                    pslverr_o,
    input  wire logic               elevated_preload_voltage_i,
    input  wire logic               dev_clk_i,
    input  wire logic [NUM_IN-1:0]  in_pins_i,
    input  wire logic [NUM_OUT-1:0] core_d_i,
    input  wire logic [NUM_OUT-1:0] core_oe_i,
    input  wire logic [NUM_OUT-1:0] io_in_i,
    output logic      [NUM_OUT-1:0] io_out_o,
    output logic      [NUM_OUT-1:0] io_oe_o,
    output logic                    power_active_o
);

    // Quiet time rounds down, never below one cycle. At this clock one cycle
    // equals the quiet interval; a faster clock only raises the count, so the
    // standby delay stays close to its target in time
    localparam int QUIET_RAW    = `RPW_QUIET_NS / `RPW_CLK_PERIOD_NS;
    localparam int QUIET_CYCLES = (QUIET_RAW < 1) ? 1 : QUIET_RAW;
    localparam int QW           = $clog2(QUIET_CYCLES + 1);
    localparam int SW           = NUM_IN + NUM_OUT + 2;

    // Refuse sizes the register map cannot hold
    generate
        if (NUM_OUT < 1 || NUM_OUT > 16 || NUM_IN < 1 || NUM_IN > 32)
        begin : g_bad_size
            $error("rpw_top: NUM_OUT must be 1..16 and NUM_IN 1..32");
        end
        // A clock slower than the quiet interval could not time it at all
        if (`RPW_CLK_PERIOD_NS > `RPW_QUIET_NS)
        begin : g_bad_clock
            $error("rpw_top: clock period exceeds the quiet interval");
        end
    endgenerate

    // All state in one record, so the clock enable freezes it in one place
    typedef struct packed {
        logic [SW-1:0]      sync1;
        logic [SW-1:0]      sync2;
        logic [SW-1:0]      sync3;
        logic [SW-1:0]      filt;
        logic [1:0]         seed;
        logic               turbo_prog;
        logic [NUM_OUT-1:0] inv_prog;
        logic [3:0]         pre_idx;
        logic               turbo;
        logic [NUM_OUT-1:0] inv;
        logic [NUM_OUT-1:0] q;
        logic [NUM_OUT-1:0] pin_out;
        logic [NUM_OUT-1:0] pin_oe;
        logic [QW-1:0]      quiet;
        rpw_state_t         state;
        logic [31:0]        rdata;
    } rpw_regs_t;

    rpw_regs_t st_r;
    rpw_regs_t st_nxt;

    // Register decode, shared by read and write paths
    // Code 0 marks an unmapped address and raises the slave error
    function automatic logic [2:0] rpw_decode(input logic [11:0] addr);
        case (addr)
            `RPW_CTRL_OFS:      rpw_decode = 3'h1;
            `RPW_OUT_CFG_OFS:   rpw_decode = 3'h2;
            `RPW_PRE_IDX_OFS:   rpw_decode = 3'h3;
            `RPW_STATUS_OFS:    rpw_decode = 3'h4;
            `RPW_OUT_STATE_OFS: rpw_decode = 3'h5;
            default:            rpw_decode = 3'h0;
        endcase
    endfunction : rpw_decode

    logic [SW-1:0]      raw_pins;
    logic [SW-1:0]      filt_new;
    logic [NUM_IN-1:0]  in_f;
    logic [NUM_OUT-1:0] io_f;
    logic               pre_f;
    logic               dclk_f;
    logic               dclk_rise;
    logic               seeded;
    logic               pin_edge;
    logic               fb_edge;
    logic               wr_en;
    logic               rd_setup;
    logic [2:0]         dec;
    logic [NUM_OUT-1:0] q_next;

    assign raw_pins = {elevated_preload_voltage_i, dev_clk_i, io_in_i, in_pins_i};

    // A pin change counts once the second and third stages agree. Until the
    // stages are seeded after reset the filter just follows the second stage,
    // so a pin that idles away from the reset level raises no false edge
    generate
        for (genvar b = 0; b < SW; b++)
        begin : g_filt
            assign filt_new[b] = !seeded ? st_r.sync2[b] :
                                 (st_r.sync2[b] == st_r.sync3[b]) ? st_r.sync3[b] : st_r.filt[b];
        end
    endgenerate

    assign in_f   = st_r.filt[NUM_IN-1:0];
    assign io_f   = st_r.filt[NUM_IN +: NUM_OUT];
    assign dclk_f = st_r.filt[SW-2];
    assign pre_f  = st_r.filt[SW-1];

    // Edges count only once the stages hold real pin levels
    assign seeded    = (st_r.seed == 2'h3);
    assign dclk_rise = seeded & filt_new[SW-2] & ~dclk_f;
    assign pin_edge  = seeded & (filt_new != st_r.filt);
    assign dec       = rpw_decode(paddr_i);
    assign wr_en     = psel_i & penable_i & pwrite_i;
    assign rd_setup  = psel_i & ~penable_i;

    // Output register next value: preload one register, or normal clocking
    always_comb
    begin
        q_next = st_r.q;
        if (dclk_rise && st_r.state != RPW_ST_UNCONF)
        begin
            if (pre_f)
            begin
                if (32'(st_r.pre_idx) < NUM_OUT)
                begin
                    q_next[st_r.pre_idx] = io_f[st_r.pre_idx];
                end
            end
            else
            begin
                q_next = core_d_i;
            end
        end
    end

    // Register feedback changes wake the detector as pins do
    // Using the next value wakes the block in the same cycle as the load
    assign fb_edge = (q_next != st_r.q);

    // Next state of everything
    always_comb
    begin
        st_nxt       = st_r;
        st_nxt.sync1 = raw_pins;
        st_nxt.sync2 = st_r.sync1;
        st_nxt.sync3 = st_r.sync2;
        st_nxt.filt  = filt_new;
        st_nxt.q     = q_next;

        // Seed counter stops once the stages are filled
        if (!seeded)
        begin
            st_nxt.seed = st_r.seed + 2'h1;
        end

        // Programmed cells written over the bus
        if (wr_en)
        begin
            case (dec)
                3'h1:    st_nxt.turbo_prog = pwdata_i[`RPW_CTRL_TURBO_BIT];
                3'h2:    st_nxt.inv_prog   = pwdata_i[NUM_OUT-1:0];
                3'h3:    st_nxt.pre_idx    = pwdata_i[3:0];
                default: st_nxt.turbo_prog = st_r.turbo_prog;
            endcase
        end

        // Power state; the turbo and polarity cells take effect only at the first pin transition, the preload index at once
        case (st_r.state)
            // Before configuration an edge only configures; the clock pin waits
            RPW_ST_UNCONF:
            begin
                if (pin_edge)
                begin
                    st_nxt.turbo = st_r.turbo_prog;
                    st_nxt.inv   = st_r.inv_prog;
                    st_nxt.state = RPW_ST_ACTIVE;
                    st_nxt.quiet = QW'(QUIET_CYCLES);
                end
            end
            RPW_ST_STANDBY:
            begin
                if (pin_edge || fb_edge || st_r.turbo)
                begin
                    st_nxt.state = RPW_ST_ACTIVE;
                    st_nxt.quiet = QW'(QUIET_CYCLES);
                end
            end
            RPW_ST_ACTIVE:
            begin
                // Any edge within a quiet window reloads it, so 25 ns edges hold it up
                if (pin_edge || fb_edge || st_r.turbo)
                begin
                    st_nxt.quiet = QW'(QUIET_CYCLES);
                end
                else if (st_r.quiet > QW'(1))
                begin
                    st_nxt.quiet = st_r.quiet - QW'(1);
                end
                else
                begin
                    st_nxt.quiet = '0;
                    st_nxt.state = RPW_ST_STANDBY;
                end
            end
            default:
            begin
                st_nxt.state = RPW_ST_UNCONF;
            end
        endcase

        // Pins: driven only once configured and outside preload
        // Polarity applies after capture, so a preload stores the raw pin level
        st_nxt.pin_out = q_next ^ st_r.inv;
        if (st_r.state == RPW_ST_UNCONF || pre_f)
        begin
            st_nxt.pin_oe = '0;
        end
        else
        begin
            st_nxt.pin_oe = core_oe_i;
        end

        // Read data captured in the setup phase, shown in the access phase
        if (rd_setup)
        begin
            st_nxt.rdata = '0;
            case (dec)
                3'h1: st_nxt.rdata[`RPW_CTRL_TURBO_BIT] = st_r.turbo_prog;
                3'h2: st_nxt.rdata[NUM_OUT-1:0] = st_r.inv_prog;
                3'h3: st_nxt.rdata[3:0] = st_r.pre_idx;
                3'h4:
                begin
                    st_nxt.rdata[`RPW_STAT_ACTIVE_BIT]  = (st_r.state == RPW_ST_ACTIVE);
                    st_nxt.rdata[`RPW_STAT_CONFIG_BIT]  = (st_r.state != RPW_ST_UNCONF);
                    st_nxt.rdata[`RPW_STAT_PRELOAD_BIT] = pre_f;
                    st_nxt.rdata[3]                     = st_r.turbo;
                    st_nxt.rdata[31:16]                 = 16'(st_r.inv);
                end
                3'h5:
                begin
                    st_nxt.rdata[15:0]  = 16'(st_r.q);
                    st_nxt.rdata[31:16] = 16'(io_f);
                end
                default: st_nxt.rdata = '0;
            endcase
        end
    end

    // Single register stage for all state; clock enable freezes it
    // A bus transfer made while the enable is low is lost, not delayed
    always_ff @(posedge clk_i)
    begin
        if (reset_i)
        begin
            st_r            <= '0;
            st_r.turbo_prog <= `RPW_CTRL_RST;
            st_r.pre_idx    <= `RPW_PRE_IDX_RST;
            st_r.state      <= RPW_ST_UNCONF;
        end
        else if (ce_i)
        begin
            st_r <= st_nxt;
        end
    end

    // Zero-wait APB slave; unmapped addresses raise an error
    assign pready_o       = 1'b1;
    assign pslverr_o      = psel_i & penable_i & (dec == 3'h0);
    assign prdata_o       = st_r.rdata;
    assign io_out_o       = st_r.pin_out;
    assign io_oe_o        = st_r.pin_oe;
    assign power_active_o = (st_r.state == RPW_ST_ACTIVE);

    // Unused inputs of the status path are folded away here
    // Dedicated inputs matter only to the transition detector in this block
    logic unused_in;
    assign unused_in = ^in_f;

endmodule : rpw_top

// File: rtl/rpw_map.svh
`ifndef RPW_MAP_SVH
`define RPW_MAP_SVH

// Register byte offsets
`define RPW_CTRL_OFS      12'h000
`define RPW_OUT_CFG_OFS   12'h004
`define RPW_PRE_IDX_OFS   12'h008
`define RPW_STATUS_OFS    12'h00c
`define RPW_OUT_STATE_OFS 12'h010

// Field positions
`define RPW_CTRL_TURBO_BIT   0
`define RPW_STAT_ACTIVE_BIT  0
`define RPW_STAT_CONFIG_BIT  1
`define RPW_STAT_PRELOAD_BIT 2

// Reset values
`define RPW_CTRL_RST    1'b0
`define RPW_PRE_IDX_RST 4'h0

// Timing
`define RPW_CLK_PERIOD_NS 40
`define RPW_QUIET_NS      40
`define RPW_FAST_EDGE_NS  25

`endif

// File: rtl/rpw_pkg.sv
package rpw_pkg;

    // Power and configuration state of the device
    typedef enum logic [1:0] {
        RPW_ST_UNCONF  = 2'b00,
        RPW_ST_STANDBY = 2'b01,
        RPW_ST_ACTIVE  = 2'b10
    } rpw_state_t;

endpackage : rpw_pkg

// File: tb/rpw_checker.sv
`timescale 1ns/100ps
module rpw_checker #(
    parameter int NUM_IN  = 12,
    parameter int NUM_OUT = 10
)(
    input wire logic               clk_i,
    input wire logic               reset_i,
    input wire logic               psel_i,
    input wire logic               penable_i,
    input wire logic [11:0]        paddr_i,
    input wire logic               pready_o,
    input wire logic               pslverr_o,
    input wire logic               elevated_preload_voltage_i,
    input wire logic               dev_clk_i,
    input wire logic [NUM_IN-1:0]  in_pins_i,
    input wire logic [NUM_OUT-1:0] io_out_o,
    input wire logic [NUM_OUT-1:0] io_oe_o,
    input wire logic               power_active_o
);
    logic [3:0] ev_cnt_r;
    default clocking @(posedge clk_i); endclocking
    default disable iff (reset_i);
    // Age of the last pin event; outputs may only move shortly after one
    always_ff @(posedge clk_i)
        if (reset_i || $changed(dev_clk_i) || $changed(in_pins_i) || $changed(elevated_preload_voltage_i))
            ev_cnt_r <= 4'h0;
        else if (ev_cnt_r != 4'hf)
            ev_cnt_r <= ev_cnt_r + 4'h1;
    // A burst of input edges, and a select held long enough to pass the sync
    sequence s_burst;
        $changed(in_pins_i) [*8];
    endsequence
    sequence s_preload;
        elevated_preload_voltage_i [*7];
    endsequence
    a_ready_high: assert property (pready_o) else $error("pready low");
    a_err_unmapped: assert property (psel_i && penable_i && paddr_i > 12'h010 |-> pslverr_o)
        else $error("no error on unmapped address");
    a_err_mapped: assert property (psel_i && penable_i && paddr_i <= 12'h010 && paddr_i[1:0] == 2'h0 |-> !pslverr_o)
        else $error("error on mapped address");
    a_reset_quiet: assert property ($fell(reset_i) |-> !(|io_oe_o) && !power_active_o)
        else $error("outputs live after reset");
    a_wake_edge: assert property ($changed(in_pins_i) |-> ##[1:8] power_active_o)
        else $error("no wake after input edge");
    a_fast_edges: assert property (s_burst |-> power_active_o)
        else $error("standby during edge burst");
    a_preload_off: assert property (s_preload |-> !(|io_oe_o))
        else $error("pin driven during preload");
    a_out_cause: assert property ($changed(io_out_o) |-> ev_cnt_r < 4'h8)
        else $error("output moved without a cause");
endmodule : rpw_checker

bind rpw_top rpw_checker #(.NUM_IN(NUM_IN), .NUM_OUT(NUM_OUT)) i_chk (
    .clk_i(clk_i), .reset_i(reset_i), .psel_i(psel_i), .penable_i(penable_i), .paddr_i(paddr_i),
    .pready_o(pready_o), .pslverr_o(pslverr_o), .elevated_preload_voltage_i(elevated_preload_voltage_i),
    .dev_clk_i(dev_clk_i), .in_pins_i(in_pins_i), .io_out_o(io_out_o), .io_oe_o(io_oe_o),
    .power_active_o(power_active_o));

// File: tb/rpw_tester.sv
`timescale 1ns/100ps
module rpw_tester (
    input  wire logic       clk_i,
    input  wire logic       start_i,
    input  wire logic       pre_i,
    input  wire logic [3:0] idx_i,
    input  wire logic       lvl_i,
    input  wire logic [9:0] io_out_i,
    input  wire logic [9:0] io_oe_i,
    output logic            sel_o,
    output logic            dclk_o,
    output logic [9:0]      io_in_o,
    output logic            busy_o
);
    logic [4:0] step_r = 5'h00;
    logic       drv_w;
    // Four clocks per phase, 160 ns, except six from clock fall to pin release, inside the allowed interval
    always @(posedge clk_i)
        if (step_r != 5'h00 || start_i)
            step_r <= (step_r == 5'h18) ? 5'h00 : step_r + 5'h01;
    assign busy_o = step_r != 5'h00;
    // Select rises while the clock pin is low, falls last
    assign sel_o  = pre_i && step_r >= 5'h01 && step_r <= 5'h16;
    // Valid level on the target pin, released before select drops
    assign drv_w  = pre_i && step_r >= 5'h05 && step_r <= 5'h12;
    // A single clock pulse per sequence
    assign dclk_o = step_r >= 5'h09 && step_r <= 5'h0c;
    // Floating pins show the inverse level so a stale value never passes
    always_comb
    begin
        io_in_o = (io_oe_i & io_out_i) | (~io_oe_i & ~io_out_i);
        if (drv_w && idx_i < 4'ha)
            io_in_o[idx_i] = lvl_i;
    end
endmodule : rpw_tester

// File: tb/rpw_top_tb.sv
`timescale 1ns/100ps
module rpw_top_tb;
    logic        clk_i = 1'b0, reset_i = 1'b1, psel_i = 1'b0, penable_i = 1'b0, pwrite_i = 1'b0;
    logic [11:0] paddr_i = 12'h000, in_pins_i = 12'h000;
    logic [31:0] pwdata_i = 32'h0, prdata_o, rd;
    logic        pready_o, pslverr_o, power_active_o, sel, dclk, busy, err;
    logic        start = 1'b0, pre = 1'b0, lvl = 1'b0, ce = 1'b1;
    logic [3:0]  idx = 4'h0;
    logic [9:0]  core_d_i = 10'h2b6, core_oe_i = 10'h3ff, io_out_o, io_oe_o, io_in, exp_q;
    logic [3:0]  pidx [4] = '{4'h0, 4'h9, 4'h2, 4'ha};
    logic        plvl [4] = '{1'b1, 1'b0, 1'b0, 1'b1};
    int          fail_count = 0, num_checks = 0, n;
    always #20 clk_i = ~clk_i;
    rpw_top i_dut (.clk_i(clk_i), .reset_i(reset_i), .ce_i(ce), .psel_i(psel_i), .penable_i(penable_i),
        .pwrite_i(pwrite_i), .paddr_i(paddr_i), .pwdata_i(pwdata_i), .prdata_o(prdata_o), .pready_o(pready_o),
        .pslverr_o(pslverr_o), .elevated_preload_voltage_i(sel), .dev_clk_i(dclk), .in_pins_i(in_pins_i),
        .core_d_i(core_d_i), .core_oe_i(core_oe_i), .io_in_i(io_in), .io_out_o(io_out_o), .io_oe_o(io_oe_o),
        .power_active_o(power_active_o));
    rpw_tester i_tester (.clk_i(clk_i), .start_i(start), .pre_i(pre), .idx_i(idx), .lvl_i(lvl),
        .io_out_i(io_out_o), .io_oe_i(io_oe_o), .sel_o(sel), .dclk_o(dclk), .io_in_o(io_in), .busy_o(busy));
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        num_checks++;
        if (seen !== exp)
        begin
            fail_count++;
            $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask : check
    task automatic stop_test;
        $display("checks %0d mismatches %0d", num_checks, fail_count);
        if (fail_count == 0 && num_checks > 0)
            $display("== PASSED ==");
        else
            $display("== FAILED ==");
        $finish;
    endtask : stop_test
    // Counts a hang as a mismatch and closes the run
    task automatic hang(input logic stuck);
        if (stuck)
        begin
            fail_count++;
            stop_test();
        end
    endtask : hang
    // One APB transfer; request held until pready is seen high
    task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] wd);
        int k;
        psel_i <= 1'b1;
        pwrite_i <= w;
        paddr_i <= a;
        pwdata_i <= wd;
        @(posedge clk_i);
        penable_i <= 1'b1;
        for (k = 0; k == 0 || (pready_o !== 1'b1 && k < 16); k++)
            @(posedge clk_i);
        rd = prdata_o;
        err = pslverr_o;
        psel_i <= 1'b0;
        penable_i <= 1'b0;
        hang(pready_o !== 1'b1);
        // An idle edge keeps a following call from driving psel twice at once
        @(posedge clk_i);
    endtask : apb
    // Runs one tester sequence, then lets the pin synchronisers settle
    task automatic tester(input logic p, input logic [3:0] i, input logic l);
        pre <= p;
        idx <= i;
        lvl <= l;
        start <= 1'b1;
        @(posedge clk_i);
        start <= 1'b0;
        @(posedge clk_i);
        for (n = 0; busy && n < 40; n++)
            @(posedge clk_i);
        hang(busy);
        repeat (8) @(posedge clk_i);
    endtask : tester
    // Toggles an input and waits a bounded time for the wake-up
    task automatic wake;
        in_pins_i <= in_pins_i ^ 12'h001;
        for (n = 0; n < 10 && power_active_o !== 1'b1; n++)
            @(posedge clk_i);
        check(power_active_o, 1'b1);
    endtask : wake
    initial
    begin
        repeat (5) @(posedge clk_i);
        reset_i <= 1'b0; // Known start for registered feedback
        apb(1'b0, 12'h00c, 32'h0);
        check(rd[1:0], 2'h0);
        apb(1'b0, 12'h008, 32'h0);
        check(rd, 32'h0);
        // With the clock enable low the write must be lost
        ce <= 1'b0;
        apb(1'b1, 12'h008, 32'h7);
        ce <= 1'b1;
        apb(1'b0, 12'h008, 32'h0);
        check(rd, 32'h0);
        apb(1'b0, 12'h020, 32'h0);
        check(err, 1'b1);
        check(rd, 32'h0);
        apb(1'b1, 12'h004, 32'h204);
        tester(1'b0, 4'h0, 1'b0);
        apb(1'b0, 12'h010, 32'h0);
        check(rd[9:0], 10'h000);
        wake();
        repeat (6) @(posedge clk_i);
        check(power_active_o, 1'b0);
        apb(1'b0, 12'h00c, 32'h0);
        check({rd[31:16], rd[1]}, 17'h00409);
        for (n = 0; n < 14; n++)
        begin
            // Two pins take turns, so an edge lands every cycle while each
            // level still outlasts the pin filter
            in_pins_i <= in_pins_i ^ (n[0] ? 12'h400 : 12'h800);
            @(posedge clk_i);
            if (n > 7)
                check(power_active_o, 1'b1);
        end
        tester(1'b0, 4'h0, 1'b0);
        exp_q = core_d_i;
        for (int k = 0; k < 4; k++)
        begin
            apb(1'b1, 12'h008, {28'h0, pidx[k]});
            tester(1'b1, pidx[k], plvl[k]);
            if (pidx[k] < 4'ha)
                exp_q[pidx[k]] = plvl[k];
            apb(1'b0, 12'h010, 32'h0);
            check(rd[9:0], exp_q);
            check(io_out_o, exp_q ^ 10'h204);
            check(io_oe_o, core_oe_i);
        end
        reset_i <= 1'b1;
        repeat (2) @(posedge clk_i);
        reset_i <= 1'b0;
        apb(1'b1, 12'h000, 32'h1);
        wake();
        repeat (20) @(posedge clk_i);
        check(power_active_o, 1'b1);
        stop_test();
    end
endmodule : rpw_top_tb
